/* core/etp_pkg.sv */
/*
 * etp_pkg: constants shared by the timestamp input control block:
 * register offsets, field positions, reset values, capacities, timing.
 * Assumes a 16-bit register port with byte addresses and a 200 MHz
 * system clock.
 */
package etp_pkg;
   localparam int NUM_UNITS = 12;
   localparam int NUM_GPIO = 7;
   localparam int ADDR_W = 11;
   localparam int DATA_W = 16;
   localparam int VEC_W = 12;
   localparam int CFG_W = 12;
   localparam int CNT_W = 4;
   localparam int SEL_W = 4;
   localparam int UNIT_SHIFT = 5;

   localparam logic [10:0] ADDR_READY = 11'h400;
   localparam logic [10:0] ADDR_ENABLE = 11'h402;
   localparam logic [10:0] ADDR_SWRST = 11'h404;
   localparam logic [10:0] ADDR_UNIT_BASE = 11'h420;
   localparam logic [10:0] ADDR_UNIT_END = 11'h5A0;
   localparam logic [4:0] UNIT_OFS_STATUS = 5'h00;
   localparam logic [4:0] UNIT_OFS_CFG = 5'h02;

   localparam int ST_OVFL_BIT = 0;
   localparam int ST_CNT_LSB = 1;
   localparam int CFG_CASC_BIT = 0;
   localparam int CFG_TAIL_BIT = 5;
   localparam int CFG_FALL_BIT = 6;
   localparam int CFG_RISE_BIT = 7;
   localparam int CFG_SEL_LSB = 8;

   localparam logic [11:0] VEC_RST = 12'h000;
   localparam logic [11:0] CFG_RST = 12'h000;
   localparam logic [3:0] CNT_RST = 4'h0;
   localparam logic [3:0] CNT_MAX = 4'hF;
   localparam logic [3:0] CAP_CASC = 4'h2;
   localparam logic [3:0] CAP_CASC_LAST = 4'h8;
   localparam logic [3:0] SEL_LAST = 4'h6;

   localparam int CLK_PERIOD_PS = 5000;
   localparam int EVENT_RATE_KHZ = 25000;
   localparam int EVENT_PERIOD_PS = 1000000000 / EVENT_RATE_KHZ;
   localparam int EVENT_PERIOD_CYC = EVENT_PERIOD_PS / CLK_PERIOD_PS;
endpackage

/* core/etp_unit.sv */
/*
 * etp_unit: one timestamp input unit: pin select, edge detection,
 * saturating event counter, overflow and ready flags.
 * Assumes synchronised pin inputs and one-cycle control pulses.
 */
`timescale 1ns/1ps
module etp_unit
   import etp_pkg::*;
#(
   parameter logic [3:0] CAP_NONTAIL = CAP_CASC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [NUM_GPIO-1:0] gpio_s,
   input wire logic unit_en,
   input wire logic [CFG_W-1:0] cfg,
   input wire logic clr_cnt,
   input wire logic clr_flag,
   input wire logic soft_rst,
   output logic [CNT_W-1:0] cnt_q,
   output logic ovfl_q,
   output logic rdy_q
);
   logic [SEL_W-1:0] sel;
   logic sel_ok;
   logic pin;
   logic prev_q;
   logic casc;
   logic tail;
   logic [CNT_W-1:0] cap;
   logic full;
   logic evt;

   // pin select, unused codes pick nothing
   assign sel = cfg[CFG_SEL_LSB +: SEL_W];
   assign sel_ok = (sel <= SEL_LAST);
   assign pin = sel_ok ? gpio_s[sel[2:0]] : 1'b0;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= pin;
      end
   end

   // one edge per clock is enough for the top event rate
   assign evt = unit_en && sel_ok &&
      ((cfg[CFG_RISE_BIT] && pin && !prev_q) ||
       (cfg[CFG_FALL_BIT] && !pin && prev_q));

   assign casc = cfg[CFG_CASC_BIT];
   assign tail = cfg[CFG_TAIL_BIT];
   assign cap = (!casc || tail) ? CNT_MAX : CAP_NONTAIL;
   assign full = (cnt_q >= cap);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= CNT_RST;
      end else if (soft_rst || clr_cnt) begin
         cnt_q <= CNT_RST;
      end else if (evt && !full) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ovfl_q <= 1'b0;
      end else if (soft_rst || clr_flag) begin
         ovfl_q <= 1'b0;
      end else if (evt && full && (!casc || tail)) begin
         ovfl_q <= 1'b1;
      end
   end

   // disable clear wins so a disabled unit never reads ready
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdy_q <= 1'b0;
      end else if (soft_rst || clr_flag) begin
         rdy_q <= 1'b0;
      end else if (evt) begin
         rdy_q <= 1'b1;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_cnt_hold_full: assert property (
      evt && full && !soft_rst && !clr_cnt |=> $stable(cnt_q))
      else $error("counter moved past capacity");
   a_cnt_step: assert property (
      evt && !full && !soft_rst && !clr_cnt |=>
      cnt_q == $past(cnt_q) + 4'h1)
      else $error("event not counted");
   a_ovfl_tail_only: assert property (
      $rose(ovfl_q) |-> !$past(casc) || $past(tail))
      else $error("non-tail unit set overflow");
   a_sel_unused: assert property (
      !sel_ok |-> !evt)
      else $error("unused pin code produced event");
endmodule

/* core/etp_ctrl.sv */
/*
 * etp_ctrl: shared control and status of twelve timestamp input units:
 * ready, enable and soft reset vectors, per-unit status and config.
 * Assumes a synchronous 16-bit register port on sys_clk, asynchronous
 * pin inputs, and the interrupt enable level from elsewhere.
 */
`timescale 1ns/1ps
module etp_ctrl
   import etp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata_q,
   output logic reg_rvalid_q,
   input wire logic [NUM_GPIO-1:0] gpio_in,
   input wire logic capture_interrupt_enable,
   output logic capture_irq_q
);
   localparam int EV_CYC = EVENT_PERIOD_CYC;

   logic [NUM_GPIO-1:0] gpio_m_q;
   logic [NUM_GPIO-1:0] gpio_s_q;
   logic [VEC_W-1:0] en_q;
   logic [VEC_W-1:0] en_d;
   logic [VEC_W-1:0] swrst_q;
   logic [VEC_W-1:0] swrst_d;
   logic [VEC_W-1:0] clr_cnt;
   logic [VEC_W-1:0] clr_flag;
   logic [VEC_W-1:0] rdy_vec;
   logic [VEC_W-1:0] ovfl_vec;
   logic [CFG_W-1:0] cfg_q [NUM_UNITS];
   logic [CNT_W-1:0] cnt_w [NUM_UNITS];
   logic en_wr;
   logic sw_wr;
   logic unit_hit;
   logic [ADDR_W-1:0] unit_rel;
   logic [3:0] uidx;
   logic [4:0] uofs;
   logic cfg_wr;
   logic [DATA_W-1:0] rdata_d;
   logic irq_d;

   // two-flop synchroniser for the pins
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gpio_m_q <= '0;
         gpio_s_q <= '0;
      end else begin
         gpio_m_q <= gpio_in;
         gpio_s_q <= gpio_m_q;
      end
   end

   // address decode
   assign en_wr = reg_wr && (reg_addr == ADDR_ENABLE);
   assign sw_wr = reg_wr && (reg_addr == ADDR_SWRST);
   assign unit_hit = (reg_addr >= ADDR_UNIT_BASE) &&
      (reg_addr < ADDR_UNIT_END);
   assign unit_rel = reg_addr - ADDR_UNIT_BASE;
   assign uidx = unit_rel[UNIT_SHIFT +: 4];
   assign uofs = unit_rel[UNIT_SHIFT-1:0];
   assign cfg_wr = reg_wr && unit_hit && (uofs == UNIT_OFS_CFG);

   // enable write strobes toward the units
   assign clr_cnt = en_wr ? reg_wdata[VEC_W-1:0] : VEC_RST;
   assign clr_flag = en_wr ? ~reg_wdata[VEC_W-1:0] : VEC_RST;

   // enable vector, soft reset forces a unit off
   always_comb begin
      en_d = en_q;
      if (en_wr) begin
         en_d = reg_wdata[VEC_W-1:0];
      end
      en_d = en_d & ~swrst_q;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         en_q <= VEC_RST;
      end else begin
         en_q <= en_d;
      end
   end

   // soft reset bits are one-cycle, self-clearing
   assign swrst_d = sw_wr ? reg_wdata[VEC_W-1:0] : VEC_RST;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         swrst_q <= VEC_RST;
      end else begin
         swrst_q <= swrst_d;
      end
   end

   // per-unit config and unit instances
   for (genvar i = 0; i < NUM_UNITS; i++) begin : g_unit
      localparam logic [3:0] CAP_NT =
         (i == NUM_UNITS - 1) ? CAP_CASC_LAST : CAP_CASC;

      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            cfg_q[i] <= CFG_RST;
         end else if (swrst_q[i]) begin
            cfg_q[i] <= CFG_RST;
         end else if (cfg_wr && (uidx == 4'(i))) begin
            cfg_q[i] <= reg_wdata[CFG_W-1:0];
         end
      end

      etp_unit #(
         .CAP_NONTAIL(CAP_NT)
      ) u_unit (
         .sys_clk(sys_clk),
         .rst(rst),
         .gpio_s(gpio_s_q),
         .unit_en(en_q[i]),
         .cfg(cfg_q[i]),
         .clr_cnt(clr_cnt[i]),
         .clr_flag(clr_flag[i]),
         .soft_rst(swrst_q[i]),
         .cnt_q(cnt_w[i]),
         .ovfl_q(ovfl_vec[i]),
         .rdy_q(rdy_vec[i])
      );
   end

   // read mux, unmapped and reserved bits read zero
   always_comb begin
      rdata_d = '0;
      if (reg_addr == ADDR_READY) begin
         rdata_d[VEC_W-1:0] = rdy_vec;
      end else if (reg_addr == ADDR_ENABLE) begin
         rdata_d[VEC_W-1:0] = en_q;
      end else if (reg_addr == ADDR_SWRST) begin
         rdata_d[VEC_W-1:0] = swrst_q;
      end else if (unit_hit && (uofs == UNIT_OFS_STATUS)) begin
         rdata_d[ST_CNT_LSB +: CNT_W] = cnt_w[uidx];
         rdata_d[ST_OVFL_BIT] = ovfl_vec[uidx];
      end else if (unit_hit && (uofs == UNIT_OFS_CFG)) begin
         rdata_d[CFG_W-1:0] = cfg_q[uidx];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata_q <= '0;
         reg_rvalid_q <= 1'b0;
      end else begin
         reg_rdata_q <= reg_rd ? rdata_d : '0;
         reg_rvalid_q <= reg_rd;
      end
   end

   // interrupt
   assign irq_d = capture_interrupt_enable && (|rdy_vec);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         capture_irq_q <= 1'b0;
      end else begin
         capture_irq_q <= irq_d;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_ready_read_map: assert property (
      reg_rd && (reg_addr == ADDR_READY) |=>
      reg_rvalid_q && (reg_rdata_q[VEC_W-1:0] == $past(rdy_vec)))
      else $error("ready read does not match unit flags");

   a_irq_from_ready: assert property (
      capture_interrupt_enable && (|rdy_vec) |=> capture_irq_q)
      else $error("interrupt not raised for ready unit");

   a_irq_no_cause: assert property (
      !capture_interrupt_enable || (rdy_vec == VEC_RST) |=>
      !capture_irq_q)
      else $error("interrupt without ready unit");

   a_ready_disabled: assert property (
      (rdy_vec & ~en_q) == VEC_RST)
      else $error("disabled unit shows ready");

   a_en_reset_off: assert property (
      $fell(rst) |-> (en_q == VEC_RST) && (swrst_q == VEC_RST) &&
      (cfg_q[0] == CFG_RST))
      else $error("enable not off after reset");

   a_reset_outputs: assert property (
      $fell(rst) |-> !capture_irq_q && !reg_rvalid_q &&
      (reg_rdata_q == '0))
      else $error("outputs not idle after reset");

   a_rvalid_follow: assert property (
      reg_rd |=> reg_rvalid_q)
      else $error("read not answered");

   a_rdata_idle: assert property (
      !reg_rd |=> !reg_rvalid_q && (reg_rdata_q == '0))
      else $error("read data not idle");

   a_en_read_map: assert property (
      reg_rd && (reg_addr == ADDR_ENABLE) |=>
      reg_rdata_q[VEC_W-1:0] == $past(en_q))
      else $error("enable read does not match");

   a_en_write_lands: assert property (
      en_wr && (swrst_q == VEC_RST) |=>
      en_q == VEC_W'($past(reg_wdata)))
      else $error("enable write not applied");

   a_en_hold: assert property (
      !en_wr && (swrst_q == VEC_RST) |=> $stable(en_q))
      else $error("enable changed without write");

   a_swrst_pulse: assert property (
      !sw_wr |=> swrst_q == VEC_RST)
      else $error("soft reset bit did not clear");

   a_swrst_write: assert property (
      sw_wr |=>
      swrst_q == VEC_W'($past(reg_wdata)))
      else $error("soft reset write not applied");

   a_swrst_read_map: assert property (
      reg_rd && (reg_addr == ADDR_SWRST) |=>
      reg_rdata_q[VEC_W-1:0] == $past(swrst_q))
      else $error("soft reset read does not match");

   a_status_read: assert property (
      reg_rd && (reg_addr == ADDR_UNIT_BASE) |=>
      (reg_rdata_q[ST_CNT_LSB +: CNT_W] == $past(cnt_w[0])) &&
      (reg_rdata_q[ST_OVFL_BIT] == $past(ovfl_vec[0])))
      else $error("status read does not match");

   a_status_rsvd: assert property (
      reg_rd && unit_hit && (uofs == UNIT_OFS_STATUS) |=>
      reg_rdata_q[DATA_W-1:ST_CNT_LSB+CNT_W] == '0)
      else $error("status reserved bits not zero");

   a_cfg_write_lands: assert property (
      cfg_wr && (uidx == 4'h0) && !swrst_q[0] |=>
      cfg_q[0] == CFG_W'($past(reg_wdata)))
      else $error("config write not applied");

   a_cfg_read_map: assert property (
      reg_rd && unit_hit && (uofs == UNIT_OFS_CFG) && (uidx == 4'h0) |=>
      reg_rdata_q[CFG_W-1:0] == $past(cfg_q[0]))
      else $error("config read does not match");

   a_cfg_rsvd: assert property (
      reg_rd && unit_hit && (uofs == UNIT_OFS_CFG) |=>
      reg_rdata_q[DATA_W-1:CFG_W] == '0)
      else $error("config reserved bits not zero");

   a_unmapped_zero: assert property (
      reg_rd && !unit_hit && (reg_addr != ADDR_READY) &&
      (reg_addr != ADDR_ENABLE) && (reg_addr != ADDR_SWRST) |=>
      reg_rdata_q == '0)
      else $error("unmapped read not zero");

   a_unit_gap_zero: assert property (
      reg_rd && unit_hit && (uofs != UNIT_OFS_STATUS) &&
      (uofs != UNIT_OFS_CFG) |=> reg_rdata_q == '0)
      else $error("unused unit word not zero");

   a_en_clr_count: assert property (
      en_wr && reg_wdata[0] |=> en_q[0] && (cnt_w[0] == CNT_RST))
      else $error("enable write did not clear counter");

   a_dis_clr_flags: assert property (
      en_wr && !reg_wdata[0] |=> !en_q[0] && !rdy_vec[0] &&
      !ovfl_vec[0] ##1 !rdy_vec[0])
      else $error("disable did not clear flags");

   a_swrst_self_clr: assert property (
      sw_wr && reg_wdata[0] |=> swrst_q[0] ##1
      !swrst_q[0] && !en_q[0] && (cfg_q[0] == CFG_RST) &&
      (cnt_w[0] == CNT_RST))
      else $error("soft reset not applied or not cleared");

   a_cap_nontail: assert property (
      cfg_q[0][CFG_CASC_BIT] && !cfg_q[0][CFG_TAIL_BIT] &&
      $stable(cfg_q[0]) && $changed(cnt_w[0]) |->
      cnt_w[0] <= CAP_CASC)
      else $error("cascade non-tail count beyond 2");

   a_cap_last: assert property (
      cfg_q[11][CFG_CASC_BIT] && !cfg_q[11][CFG_TAIL_BIT] &&
      $stable(cfg_q[11]) && $changed(cnt_w[11]) |->
      cnt_w[11] <= CAP_CASC_LAST)
      else $error("cascade unit 12 count beyond 8");

   a_ovfl_at_max: assert property (
      $rose(ovfl_vec[0]) && !cfg_q[0][CFG_CASC_BIT] |->
      cnt_w[0] == CNT_MAX)
      else $error("overflow set before count saturated");

   a_rsvd_zero: assert property (
      reg_rvalid_q |-> reg_rdata_q[DATA_W-1:VEC_W] == 4'h0)
      else $error("reserved read bits not zero");

   c_overflow: cover property (
      $rose(ovfl_vec[0]));
   c_irq: cover property (
      $rose(capture_irq_q));
   c_soft_reset: cover property (
      swrst_q[0] && en_q[0]);
   c_fast_edges: cover property (
      $changed(cnt_w[0]) && (cnt_w[0] != CNT_RST) ##[1:EV_CYC]
      $changed(cnt_w[0]) && (cnt_w[0] != CNT_RST));
   c_casc_full: cover property (
      cfg_q[11][CFG_CASC_BIT] && (cnt_w[11] == CAP_CASC_LAST));

   // per-unit checks
   for (genvar k = 0; k < NUM_UNITS; k++) begin : g_chk
      a_unit_rdy_en: assert property (@(posedge sys_clk)
         disable iff (rst) $rose(rdy_vec[k]) |-> en_q[k])
         else $error("ready set on disabled unit");

      a_unit_en_clr: assert property (@(posedge sys_clk)
         disable iff (rst) en_wr && reg_wdata[k] |=>
         cnt_w[k] == CNT_RST)
         else $error("enable write left counter");

      a_unit_dis_clr: assert property (@(posedge sys_clk)
         disable iff (rst) en_wr && !reg_wdata[k] |=>
         !rdy_vec[k] && !ovfl_vec[k])
         else $error("disable left flags set");

      a_unit_swrst: assert property (@(posedge sys_clk)
         disable iff (rst) swrst_q[k] |=>
         (cfg_q[k] == CFG_RST) && !en_q[k] && (cnt_w[k] == CNT_RST) &&
         !rdy_vec[k] && !ovfl_vec[k])
         else $error("soft reset left unit state");

      a_unit_cap_casc: assert property (@(posedge sys_clk)
         disable iff (rst)
         cfg_q[k][CFG_CASC_BIT] && !cfg_q[k][CFG_TAIL_BIT] &&
         $stable(cfg_q[k]) && $changed(cnt_w[k]) |->
         cnt_w[k] <= ((k == NUM_UNITS - 1) ? CAP_CASC_LAST : CAP_CASC))
         else $error("cascade unit counted past capacity");
   end
endmodule

/* test/etp_pin_model.sv */
/* etp_pin_model: drives the seven event pins in place of the outside.
   assumes sys_clk from the bench; pins start low. */
`timescale 1ns/1ps
module etp_pin_model
   import etp_pkg::*;
(
   input wire logic sys_clk,
   output logic [NUM_GPIO-1:0] gpio
);
   initial gpio = '0;
   // toggles one pin n times, each level held gap cycles
   task automatic toggle(input int pin, input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         gpio[pin] <= ~gpio[pin];
         repeat (gap - 1) @(posedge sys_clk);
      end
   endtask
endmodule

/* test/etp_ctrl_tb.sv */
/* etp_ctrl_tb: corner and random tests of the timestamp input control.
   assumes the pin model and the register port of etp_ctrl. */
`timescale 1ns/1ps
module etp_ctrl_tb
   import etp_pkg::*;
;
   logic sys_clk, rst, reg_wr, reg_rd, cie, reg_rvalid_q, capture_irq_q;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata_q, rd_data;
   logic [NUM_GPIO-1:0] gpio;
   logic [11:0] c;
   int errors, comparisons, seed, u, n, p;
   etp_pin_model pm (.sys_clk(sys_clk), .gpio(gpio));
   etp_ctrl dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
      .gpio_in(gpio), .capture_interrupt_enable(cie),
      .capture_irq_q(capture_irq_q));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic finish_test();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [10:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [10:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk("rvalid", 16'h0001, {15'h0, reg_rvalid_q});
      rd_data = reg_rdata_q;
   endtask
   function automatic logic [10:0] ua(input int u, input logic [10:0] o);
      return ADDR_UNIT_BASE + 11'((u - 1) * 32) + o;
   endfunction
   // status expected after ev enabled edges under config c
   function automatic logic [15:0] exp_st(input int ev, input logic [11:0] c,
      input int u);
      int cap;
      cap = (!c[CFG_CASC_BIT] || c[CFG_TAIL_BIT]) ? 15 : (u == 12 ? 8 : 2);
      return {11'h0, 4'(ev > cap ? cap : ev), 1'(ev > cap && cap == 15)};
   endfunction
   // configure, enable, pulse, check, then disable one unit
   task automatic run(input int u, input logic [11:0] c, input int pin,
      input int n);
      int ev, rises;
      rises = gpio[pin] ? n / 2 : (n + 1) / 2;
      ev = (c[CFG_RISE_BIT] ? rises : 0) + (c[CFG_FALL_BIT] ? n - rises : 0);
      if (c[11:8] > SEL_LAST) ev = 0;
      @(posedge sys_clk);
      cie <= 1'($random(seed));
      wr(ua(u, UNIT_OFS_CFG), {4'h0, c});
      repeat (8) @(posedge sys_clk);
      wr(ADDR_ENABLE, 16'(1 << (u - 1)));
      pm.toggle(pin, n, EVENT_PERIOD_CYC / 2);
      repeat (8) @(posedge sys_clk);
      rd(ua(u, UNIT_OFS_CFG));
      chk("config", {4'h0, c}, rd_data);
      rd(ua(u, UNIT_OFS_STATUS));
      chk("status", exp_st(ev, c, u), rd_data);
      rd(ADDR_READY);
      chk("ready", (ev > 0) ? 16'(1 << (u - 1)) : 16'h0000,
         rd_data);
      chk("irq", {15'h0, cie && ev > 0}, {15'h0, capture_irq_q});
      wr(ADDR_ENABLE, 16'h0000);
      rd(ua(u, UNIT_OFS_STATUS));
      chk("status off", exp_st(ev, c, u) & 16'hFFFE, rd_data);
      rd(ADDR_READY);
      chk("ready off", 16'h0000, rd_data);
      $display("unit %0d test done", u);
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      finish_test();
   end
   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      cie = 1'b0;
      seed = 32'hBA9B;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      rd(ADDR_READY);
      chk("ready reset", 16'h0000, rd_data);
      rd(ADDR_ENABLE);
      chk("enable reset", 16'h0000, rd_data);
      rd(ADDR_SWRST);
      chk("swrst reset", 16'h0000, rd_data);
      rd(ADDR_UNIT_BASE);
      chk("status reset", 16'h0000, rd_data);
      $display("reset test done");
      run(1, 12'h0C0, 0, 5);
      run(1, 12'h080, 0, 6);
      run(1, 12'h1C0, 1, 17);
      run(1, 12'h2C1, 2, 6);
      run(4, 12'h2C1, 2, 6);
      run(12, 12'h3C1, 3, 12);
      run(7, 12'h6E1, 6, 18);
      run(5, 12'h7C0, 0, 4);
      for (int i = 0; i < 10; i++) begin
         u = 1 + $unsigned($random(seed)) % 12;
         c = 12'($random(seed));
         n = $unsigned($random(seed)) % 20;
         p = c[11:8] <= SEL_LAST ? c[11:8] : $unsigned($random(seed)) % 7;
         run(u, c, p, n);
      end
      wr(ua(1, UNIT_OFS_CFG), 16'h00C0);
      wr(ADDR_ENABLE, 16'h0001);
      pm.toggle(0, 3, EVENT_PERIOD_CYC / 2);
      repeat (8) @(posedge sys_clk);
      wr(ADDR_SWRST, 16'h0001);
      repeat (2) @(posedge sys_clk);
      rd(ADDR_SWRST);
      chk("swrst clear", 16'h0000, rd_data);
      rd(ADDR_ENABLE);
      chk("enable swrst", 16'h0000, rd_data);
      rd(ua(1, UNIT_OFS_CFG));
      chk("config swrst", 16'h0000, rd_data);
      rd(ua(1, UNIT_OFS_STATUS));
      chk("status swrst", 16'h0000, rd_data);
      rd(ADDR_READY);
      chk("ready swrst", 16'h0000, rd_data);
      $display("soft reset test done");
      wr(ADDR_READY, 16'hFFFF);
      wr(ADDR_ENABLE, 16'hFFFF);
      rd(ADDR_ENABLE);
      chk("enable wide", 16'h0FFF, rd_data);
      rd(ADDR_READY);
      chk("ready ro", 16'h0000, rd_data);
      rd(11'h406);
      chk("unmapped", 16'h0000, rd_data);
      wr(ADDR_ENABLE, 16'h0000);
      $display("reserved test done");
      finish_test();
   end
endmodule
